/* hw/rbs_consts.vh */
`ifndef RBS_CONSTS_VH
`define RBS_CONSTS_VH

// Register word indexes; byte address is four times the index
`define RBS_IDX_BREAK_WAKE   16'hFE00
`define RBS_IDX_RESET_CAUSE  16'hFE01
`define RBS_IDX_BREAK_CLEAR  16'hFE03
`define RBS_IDX_IRQ_STATUS   16'hFE04
`define RBS_IDX_IRQ_MASK     16'hFE05

// Break wake status fields
`define RBS_BIT_STOP_WAIT    1
`define RBS_MASK_BREAK_WAKE  8'h02
`define RBS_RST_BREAK_WAKE   8'h00

// Reset cause fields
`define RBS_BIT_POWER_ON     7
`define RBS_BIT_PIN          6
`define RBS_BIT_WATCHDOG     5
`define RBS_BIT_BAD_OPCODE   4
`define RBS_BIT_BAD_FETCH    3
`define RBS_BIT_MONITOR      2
`define RBS_BIT_LOW_VOLTAGE  1
`define RBS_MASK_RESET_CAUSE 8'hFE
`define RBS_RST_RESET_CAUSE  8'h80

// Break clear control fields
`define RBS_BIT_CLEAR_ENABLE 7
`define RBS_MASK_BREAK_CLEAR 8'h80
`define RBS_RST_BREAK_CLEAR  8'h00

// Interrupt status and mask fields
`define RBS_BIT_IRQ_CAUSE    0
`define RBS_BIT_IRQ_WAKE     1
`define RBS_MASK_IRQ         8'h03
`define RBS_RST_IRQ          8'h00

// Reset pin timing in crystal clock ticks
`define RBS_SAMPLE_TICKS     8'd32
`define RBS_DRIVE_TICKS      8'd64

`endif

/* hw/rbs_regs.v */
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "rbs_consts.vh"

module rbs_regs
#(
    parameter                 ADDR_W      = 18,
    parameter [7:0]           DRIVE_TICKS = `RBS_DRIVE_TICKS
)
(
    // Clock, reset and enable
    input  wire               clk_sys_i,
    input  wire               rst_n_i,
    input  wire               ce_i,

    // Avalon-MM slave
    input  wire [ADDR_W-1:0]  avs_address_i,
    input  wire               avs_read_i,
    input  wire               avs_write_i,
    input  wire [31:0]        avs_writedata_i,
    input  wire [3:0]         avs_byteenable_i,
    output reg  [31:0]        avs_readdata_o,
    output wire               avs_waitrequest_o,

    // Reset sources
    input  wire               wdog_reset_i,
    input  wire               bad_opcode_reset_i,
    input  wire               bad_addr_reset_i,
    input  wire               opcode_fetch_i,
    input  wire               monitor_entry_reset_i,
    input  wire               low_voltage_reset_i,

    // Reset pin and crystal clock
    input  wire               crystal_clock_tick_i,
    input  wire               reset_pin_i,
    output wire               reset_pin_o,
    output wire               reset_pin_oe_o,
    output wire               sys_reset_o,

    // Break state
    input  wire               break_state_i,
    input  wire               wait_break_exit_i,
    output wire               break_clear_enable_o,

    // Interrupt
    output wire               irq_o
);

    localparam [3:0] ST_IDLE    = 4'b0001;
    localparam [3:0] ST_DRIVE   = 4'b0010;
    localparam [3:0] ST_RELEASE = 4'b0100;
    localparam [3:0] ST_EXTHOLD = 4'b1000;

    localparam [ADDR_W-1:0] ADDR_BREAK_WAKE  = {`RBS_IDX_BREAK_WAKE, 2'b00};
    localparam [ADDR_W-1:0] ADDR_RESET_CAUSE = {`RBS_IDX_RESET_CAUSE, 2'b00};
    localparam [ADDR_W-1:0] ADDR_BREAK_CLEAR = {`RBS_IDX_BREAK_CLEAR, 2'b00};
    localparam [ADDR_W-1:0] ADDR_IRQ_STATUS  = {`RBS_IDX_IRQ_STATUS, 2'b00};
    localparam [ADDR_W-1:0] ADDR_IRQ_MASK    = {`RBS_IDX_IRQ_MASK, 2'b00};

    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [7:0]  tick_reg;
    reg  [7:0]  tick_next;
    reg  [7:0]  wake_reg;
    reg  [7:0]  wake_next;
    reg  [7:0]  cause_reg;
    reg  [7:0]  cause_next;
    reg  [7:0]  clear_ctl_reg;
    reg  [7:0]  clear_ctl_next;
    reg  [7:0]  irq_stat_reg;
    reg  [7:0]  irq_stat_next;
    reg  [7:0]  irq_mask_reg;
    reg  [7:0]  irq_mask_next;
    reg         ack_reg;
    reg  [7:0]  rdata_next;

    wire        req;
    wire        done;
    wire        wr_done;
    wire        rd_done;
    wire        lane0;
    wire [7:0]  wdata;
    wire        clear_allowed;
    wire        internal_req;
    wire        pin_low;
    wire        sample_now;
    reg  [7:0]  cause_set;

    // Bus handshake: one wait cycle, completion on the second edge
    assign req               = avs_read_i | avs_write_i;
    // Frozen clock enable keeps the master waiting, so no access is lost
    assign avs_waitrequest_o = req & ~(ack_reg & ce_i);
    assign done              = req & ack_reg & ce_i;
    assign wr_done           = done & avs_write_i;
    assign rd_done           = done & avs_read_i;
    assign lane0             = avs_byteenable_i[0];
    assign wdata             = avs_writedata_i[7:0];

    // Wake and reset cause flag clearing is blocked inside break unless enabled
    assign clear_allowed = ~break_state_i | clear_ctl_reg[`RBS_BIT_CLEAR_ENABLE];
    assign break_clear_enable_o = clear_ctl_reg[`RBS_BIT_CLEAR_ENABLE];

    // Any internal reset source
    assign internal_req = wdog_reset_i
                        | bad_opcode_reset_i
                        | (bad_addr_reset_i & opcode_fetch_i)
                        | monitor_entry_reset_i
                        | low_voltage_reset_i;

    assign pin_low    = ~reset_pin_i;
    assign sample_now = (state_reg == ST_RELEASE) & crystal_clock_tick_i
                      & (tick_reg == `RBS_SAMPLE_TICKS - 8'd1);

    // Pin is open drain: drive low only, in power-on and internal resets
    assign reset_pin_o    = 1'b0;
    assign reset_pin_oe_o = (state_reg == ST_DRIVE);
    assign sys_reset_o    = (state_reg != ST_IDLE);

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // Reset sequencer
    always @*
    begin
        state_next = state_reg;
        tick_next  = tick_reg;
        case (state_reg)
            ST_IDLE:
            begin
                tick_next = 8'h00;
                if (internal_req)
                begin
                    state_next = ST_DRIVE;
                end
                else if (pin_low)
                begin
                    state_next = ST_EXTHOLD;
                end
            end
            ST_DRIVE:
            begin
                if (crystal_clock_tick_i)
                begin
                    if (tick_reg >= DRIVE_TICKS - 8'd1)
                    begin
                        state_next = ST_RELEASE;
                        tick_next  = 8'h00;
                    end
                    else
                    begin
                        tick_next = tick_reg + 8'd1;
                    end
                end
            end
            ST_RELEASE:
            begin
                if (internal_req)
                begin
                    state_next = ST_DRIVE;
                    tick_next  = 8'h00;
                end
                else if (sample_now)
                begin
                    // Pin still low after 32 ticks: someone outside holds it
                    state_next = pin_low ? ST_EXTHOLD : ST_IDLE;
                    tick_next  = 8'h00;
                end
                else if (crystal_clock_tick_i)
                begin
                    tick_next = tick_reg + 8'd1;
                end
            end
            ST_EXTHOLD:
            begin
                tick_next = 8'h00;
                if (internal_req)
                begin
                    state_next = ST_DRIVE;
                end
                else if (~pin_low)
                begin
                    state_next = ST_RELEASE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                tick_next  = 8'h00;
            end
        endcase
    end

    // Reset cause events
    always @*
    begin
        cause_set = 8'h00;
        cause_set[`RBS_BIT_WATCHDOG]    = wdog_reset_i;
        cause_set[`RBS_BIT_BAD_OPCODE]  = bad_opcode_reset_i;
        // Data accesses to bad addresses do not count
        cause_set[`RBS_BIT_BAD_FETCH]   = bad_addr_reset_i & opcode_fetch_i;
        cause_set[`RBS_BIT_MONITOR]     = monitor_entry_reset_i;
        cause_set[`RBS_BIT_LOW_VOLTAGE] = low_voltage_reset_i;
        cause_set[`RBS_BIT_PIN]         = (sample_now & pin_low)
                                        | ((state_reg == ST_IDLE) & pin_low & ~internal_req);
    end

    // Register next values; set wins over clear everywhere
    always @*
    begin
        wake_next      = wake_reg;
        cause_next     = cause_reg;
        clear_ctl_next = clear_ctl_reg;
        irq_stat_next  = irq_stat_reg;
        irq_mask_next  = irq_mask_reg;

        // Stop/wait flag cleared by writing zero to it
        if (wr_done && lane0 && avs_address_i == ADDR_BREAK_WAKE && clear_allowed)
        begin
            wake_next = wake_reg & (wdata | ~`RBS_MASK_BREAK_WAKE);
        end

        // Clear only the bits the read returned, so a late event survives
        if (rd_done && avs_address_i == ADDR_RESET_CAUSE && clear_allowed)
        begin
            cause_next = cause_reg & ~avs_readdata_o[7:0];
        end

        if (wr_done && lane0 && avs_address_i == ADDR_BREAK_CLEAR)
        begin
            clear_ctl_next = wdata & `RBS_MASK_BREAK_CLEAR;
        end

        if (wr_done && lane0 && avs_address_i == ADDR_IRQ_STATUS)
        begin
            irq_stat_next = irq_stat_reg & ~wdata;
        end

        if (wr_done && lane0 && avs_address_i == ADDR_IRQ_MASK)
        begin
            irq_mask_next = wdata & `RBS_MASK_IRQ;
        end

        if (wait_break_exit_i)
        begin
            wake_next[`RBS_BIT_STOP_WAIT] = 1'b1;
            irq_stat_next[`RBS_BIT_IRQ_WAKE] = 1'b1;
        end

        // Older flags stay; new causes are ORed in
        cause_next = (cause_next | cause_set) & `RBS_MASK_RESET_CAUSE;
        if (|cause_set)
        begin
            irq_stat_next[`RBS_BIT_IRQ_CAUSE] = 1'b1;
        end
    end

    // Read data mux
    always @*
    begin
        rdata_next = 8'h00;
        case (avs_address_i)
            ADDR_BREAK_WAKE:  rdata_next = wake_reg & `RBS_MASK_BREAK_WAKE;
            ADDR_RESET_CAUSE: rdata_next = cause_reg & `RBS_MASK_RESET_CAUSE;
            ADDR_BREAK_CLEAR: rdata_next = clear_ctl_reg & `RBS_MASK_BREAK_CLEAR;
            ADDR_IRQ_STATUS:  rdata_next = irq_stat_reg & `RBS_MASK_IRQ;
            ADDR_IRQ_MASK:    rdata_next = irq_mask_reg & `RBS_MASK_IRQ;
            default:          rdata_next = 8'h00;
        endcase
    end

    // Sequencer state
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Power-on starts with the pin driven low
            state_reg <= ST_DRIVE;
            tick_reg  <= 8'h00;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
            tick_reg  <= tick_next;
        end
    end

    // Registers
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wake_reg      <= `RBS_RST_BREAK_WAKE;
            cause_reg     <= `RBS_RST_RESET_CAUSE;
            clear_ctl_reg <= `RBS_RST_BREAK_CLEAR;
            irq_stat_reg  <= `RBS_RST_IRQ;
            irq_mask_reg  <= `RBS_RST_IRQ;
        end
        else if (ce_i)
        begin
            wake_reg      <= wake_next;
            cause_reg     <= cause_next;
            clear_ctl_reg <= clear_ctl_next;
            irq_stat_reg  <= irq_stat_next;
            irq_mask_reg  <= irq_mask_next;
        end
    end

    // Bus acknowledge and read data
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_reg        <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            if (req && !ack_reg)
            begin
                ack_reg        <= 1'b1;
                avs_readdata_o <= {24'h00_0000, rdata_next};
            end
            else
            begin
                ack_reg <= 1'b0;
            end
        end
    end

endmodule

/* tb/rbs_regs_properties.sv */
`timescale 1ns/1ps
module rbs_regs_props
#(
    parameter ADDR_W = 18
)
(
    // Clock and reset
    input wire              clk_sys_i,
    input wire              rst_n_i,
    input wire              ce_i,
    // Bus
    input wire [ADDR_W-1:0] avs_address_i,
    input wire              avs_read_i,
    input wire              avs_write_i,
    input wire [31:0]       avs_writedata_i,
    input wire [3:0]        avs_byteenable_i,
    input wire [31:0]       avs_readdata_o,
    input wire              avs_waitrequest_o,
    // Reset and break
    input wire              wdog_reset_i,
    input wire              reset_pin_o,
    input wire              reset_pin_oe_o,
    input wire              sys_reset_o,
    input wire              break_clear_enable_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    wire rdone = avs_read_i && !avs_waitrequest_o;

    one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
        |=> !avs_waitrequest_o) else $error("bus answer late");
    hi_zero_a: assert property (rdone |-> avs_readdata_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_read_a: assert property (rdone && avs_address_i == 18'h3F808
        |-> avs_readdata_o == 32'h00000000) else $error("unmapped read not zero");
    wake_bits_a: assert property (rdone && avs_address_i == 18'h3F800
        |-> (avs_readdata_o[7:0] & 8'hFD) == 8'h00) else $error("wake spare bits set");
    cause_bit0_a: assert property (rdone && avs_address_i == 18'h3F804
        |-> !avs_readdata_o[0]) else $error("cause bit 0 set");
    ctl_read_a: assert property (rdone && avs_address_i == 18'h3F80C
        |-> avs_readdata_o[7:0] == {break_clear_enable_o, 7'h00}) else $error("ctl read wrong");
    ctl_write_a: assert property (avs_write_i && !avs_waitrequest_o && ce_i
        && avs_byteenable_i[0] && avs_address_i == 18'h3F80C
        |=> break_clear_enable_o == $past(avs_writedata_i[7])) else $error("ctl write lost");
    drive_on_a: assert property (wdog_reset_i && ce_i && !sys_reset_o
        |=> reset_pin_oe_o) else $error("pin not driven");
    pin_low_a: assert property (reset_pin_oe_o |-> !reset_pin_o && sys_reset_o)
        else $error("pin driven high");
    release_hold_a: assert property ($fell(reset_pin_oe_o) |-> sys_reset_o [*8])
        else $error("release phase too short");
endmodule

bind rbs_regs rbs_regs_props #(.ADDR_W(ADDR_W)) u_rbs_regs_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wdog_reset_i(wdog_reset_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .sys_reset_o(sys_reset_o),
    .break_clear_enable_o(break_clear_enable_o));

/* tb/reset_break_status_regs_tb.sv */
`timescale 1ns/1ps
module reset_break_status_regs_tb;
    localparam [17:0] A_WAKE  = 18'h3F800;
    localparam [17:0] A_CAUSE = 18'h3F804;
    localparam [17:0] A_CTL   = 18'h3F80C;
    localparam [17:0] A_IST   = 18'h3F810;
    localparam [17:0] A_IMSK  = 18'h3F814;
    reg         clk_sys_i = 1'b0;
    reg         rst_n_i   = 1'b0;
    reg         rd = 1'b0, wr = 1'b0, fetch = 1'b1, tick = 1'b0, ext_low = 1'b0, brk = 1'b0;
    reg         ce    = 1'b1;
    reg  [17:0] addr  = 18'h00000;
    reg  [31:0] wdata = 32'h00000000;
    reg  [3:0]  be    = 4'h0;
    reg  [5:0]  src   = 6'h00;
    reg         ws, ss;
    reg  [31:0] rs, q;
    wire [31:0] rdata;
    wire        wreq, pin_o, oe, sysrst, bce, irq;
    wire        pin_lvl = !(oe || ext_low);
    integer     mismatches = 0, total_checks = 0, i;

    rbs_regs #(.DRIVE_TICKS(8'h04)) u_rbs_regs (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .wdog_reset_i(src[4]),
        .bad_opcode_reset_i(src[3]), .bad_addr_reset_i(src[2]), .opcode_fetch_i(fetch),
        .monitor_entry_reset_i(src[1]), .low_voltage_reset_i(src[0]),
        .crystal_clock_tick_i(tick), .reset_pin_i(pin_lvl), .reset_pin_o(pin_o),
        .reset_pin_oe_o(oe), .sys_reset_o(sysrst), .break_state_i(brk),
        .wait_break_exit_i(src[5]), .break_clear_enable_o(bce), .irq_o(irq));

    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) tick <= ~tick;
    // Mid-cycle copies avoid edge races
    always @(negedge clk_sys_i)
    begin
        ws <= wreq;
        ss <= sysrst;
        rs <= rdata;
    end

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task bus(input w, input [17:0] a, input [31:0] d, input [3:0] b);
        integer n;
        begin
            rd <= !w;
            wr <= w;
            addr <= a;
            wdata <= d;
            be <= b;
            n = 0;
            do
            begin
                @(posedge clk_sys_i);
                n = n + 1;
            end
            while (ws !== 1'b0 && n < 50);
            q = rs;
            if (n == 50)
                mismatches = mismatches + 1;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk_sys_i);
        end
    endtask

    task rd_chk(input [17:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h00000000, 4'h1);
            chk(q, e);
        end
    endtask

    task pulse(input [5:0] v);
        begin
            src <= v;
            @(posedge clk_sys_i);
            src <= 6'h00;
            @(posedge clk_sys_i);
        end
    endtask

    task wait_idle;
        integer n;
        begin
            n = 0;
            while (ss !== 1'b0 && n < 400)
            begin
                @(posedge clk_sys_i);
                n = n + 1;
            end
            if (n == 400)
                mismatches = mismatches + 1;
        end
    endtask

    task irq_chk(input e);
        begin
            repeat (2) @(posedge clk_sys_i);
            chk(irq, e);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches = mismatches + 1;
        give_verdict;
    end

    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk(oe, 1'b1);
        chk(pin_o, 1'b0);
        wait_idle;
        rd_chk(A_CAUSE, 32'h80);
        rd_chk(A_CAUSE, 32'h00);
        rd_chk(A_CTL, 32'h00);
        rd_chk(18'h3F808, 32'h00);
        $display("test reset done");
        for (i = 0; i < 5; i = i + 1)
        begin
            pulse(6'h10 >> i);
            chk(oe, 1'b1);
            wait_idle;
            rd_chk(A_CAUSE, 32'h20 >> i);
            rd_chk(A_CAUSE, 32'h00);
        end
        fetch <= 1'b0;
        pulse(6'h04);
        wait_idle;
        rd_chk(A_CAUSE, 32'h00);
        pulse(6'h10);
        wait_idle;
        pulse(6'h01);
        wait_idle;
        rd_chk(A_CAUSE, 32'h22);
        $display("test sources done");
        ext_low <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        ext_low <= 1'b0;
        wait_idle;
        rd_chk(A_CAUSE, 32'h40);
        pulse(6'h10);
        ext_low <= 1'b1;
        repeat (150) @(posedge clk_sys_i);
        ext_low <= 1'b0;
        wait_idle;
        rd_chk(A_CAUSE, 32'h60);
        $display("test pin done");
        bus(1'b1, A_CTL, 32'hFF, 4'h1);
        rd_chk(A_CTL, 32'h80);
        chk(bce, 1'b1);
        bus(1'b1, A_CTL, 32'h00, 4'h0);
        rd_chk(A_CTL, 32'h80);
        bus(1'b1, A_CTL, 32'h00, 4'h1);
        brk <= 1'b1;
        pulse(6'h10);
        wait_idle;
        rd_chk(A_CAUSE, 32'h20);
        rd_chk(A_CAUSE, 32'h20);
        bus(1'b1, A_CTL, 32'h80, 4'h1);
        rd_chk(A_CAUSE, 32'h20);
        rd_chk(A_CAUSE, 32'h00);
        brk <= 1'b0;
        $display("test break done");
        bus(1'b1, A_IST, 32'hFF, 4'h1);
        pulse(6'h20);
        rd_chk(A_WAKE, 32'h02);
        bus(1'b1, A_IMSK, 32'h02, 4'h1);
        irq_chk(1'b1);
        bus(1'b1, A_IMSK, 32'h00, 4'h1);
        irq_chk(1'b0);
        bus(1'b1, A_IMSK, 32'h02, 4'h1);
        bus(1'b1, A_IST, 32'h02, 4'h1);
        irq_chk(1'b0);
        rd_chk(A_IST, 32'h00);
        bus(1'b1, A_WAKE, 32'h00, 4'h1);
        rd_chk(A_WAKE, 32'h00);
        $display("test wake done");
        ce <= 1'b0;
        pulse(6'h10);
        chk(oe, 1'b0);
        ce <= 1'b1;
        rd_chk(A_CAUSE, 32'h00);
        $display("test enable done");
        pulse(6'h10);
        wait_idle;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk(oe, 1'b1);
        rst_n_i <= 1'b1;
        wait_idle;
        rd_chk(A_CAUSE, 32'h80);
        $display("test second reset done");
        give_verdict;
    end
endmodule
